/* cbi_irq_latch.sv */
/*
 c-bit status and counter saturation interrupt request latch with a
 classic wishbone slave, mask registers and one level interrupt output.
 assumes status and saturation flags are levels from logic on clk_i,
 and a classic single cycle wishbone master.
*/
`include "cbi_params.svh"

module cbi_irq_latch
(
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire cbi_pkg::cbi_wb_req_t wb_i,
	output cbi_pkg::cbi_wb_rsp_t      wb_o,
	input  wire logic [7:0]          cbit_status_i,
	input  wire cbi_pkg::cbi_sat_t    sat_i,
	output logic                     irq_o
);
	import cbi_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	cbi_state_t st;
	cbi_state_t next_st;
	logic [7:0] hit_cbit;
	logic [7:0] hit_sat;
	logic       start;
	logic       commit;
	logic       wr_lo;
	logic       rd_commit;
	logic [7:0] clr_cbit;
	logic [7:0] clr_sat;
	logic [7:0] rd_mux;

	// address decode against a register index
	function automatic logic idx_hit(input logic [7:0] adr, input logic [5:0] idx);
		idx_hit = (adr[7:2] == idx);
	endfunction

	// ----------------------------------------------------------------
	// edge detection
	// ----------------------------------------------------------------
	// one detector per request register
	cbi_edge8 u_edge_cbit
	(
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cond_i (cbit_status_i),
		.rise_i (st.rise),
		.fall_i (st.fall),
		.hit_o  (hit_cbit)
	);

	cbi_edge8 u_edge_sat
	(
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.cond_i (sat_i),
		.rise_i (st.rise),
		.fall_i (st.fall),
		.hit_o  (hit_sat)
	);

	// ----------------------------------------------------------------
	// bus strobes
	// ----------------------------------------------------------------
	// start of access, and the edge where ack is seen by the master
	assign start     = wb_i.cyc & wb_i.stb & ~st.ack;
	assign commit    = wb_i.cyc & wb_i.stb & st.ack;
	assign wr_lo     = commit & wb_i.we & wb_i.sel[0];
	assign rd_commit = commit & ~wb_i.we;

	// read data select, unmapped reads as zero
	always_comb
	begin
		rd_mux = 8'h00;
		if (idx_hit(wb_i.adr, `CBI_IDX_STATUS))
			rd_mux = cbit_status_i;
		else if (idx_hit(wb_i.adr, `CBI_IDX_REQ_CBIT))
			rd_mux = st.req_cbit;
		else if (idx_hit(wb_i.adr, `CBI_IDX_REQ_SAT))
			rd_mux = st.req_sat;
		else if (idx_hit(wb_i.adr, `CBI_IDX_MASK_CBIT))
			rd_mux = st.mask_cbit;
		else if (idx_hit(wb_i.adr, `CBI_IDX_MASK_SAT))
			rd_mux = st.mask_sat;
		else if (idx_hit(wb_i.adr, `CBI_IDX_EDGE_CTRL))
		begin
			rd_mux[`CBI_EDGE_RISE_BIT] = st.rise;
			rd_mux[`CBI_EDGE_FALL_BIT] = st.fall;
		end
	end

	// read clear only drops the bits that were reported
	always_comb
	begin
		clr_cbit = 8'h00;
		clr_sat  = 8'h00;
		if (rd_commit && idx_hit(wb_i.adr, `CBI_IDX_REQ_CBIT))
			clr_cbit = st.rdat;
		if (rd_commit && idx_hit(wb_i.adr, `CBI_IDX_REQ_SAT))
			clr_sat = st.rdat;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st     = st;
		next_st.ack = start;
		if (start)
			next_st.rdat = wb_i.we ? 8'h00 : rd_mux;
		if (wr_lo && idx_hit(wb_i.adr, `CBI_IDX_MASK_CBIT))
			next_st.mask_cbit = wb_i.dat[7:0];
		if (wr_lo && idx_hit(wb_i.adr, `CBI_IDX_MASK_SAT))
			next_st.mask_sat = wb_i.dat[7:0];
		if (wr_lo && idx_hit(wb_i.adr, `CBI_IDX_EDGE_CTRL))
		begin
			next_st.rise = wb_i.dat[`CBI_EDGE_RISE_BIT];
			next_st.fall = wb_i.dat[`CBI_EDGE_FALL_BIT];
		end
		// set wins over a read clear in the same cycle
		next_st.req_cbit = (st.req_cbit & ~clr_cbit) | hit_cbit;
		next_st.req_sat  = (st.req_sat & ~clr_sat) | hit_sat;
		// interrupt from the values that the registers take at this edge
		next_st.irq = (|(next_st.req_cbit & next_st.mask_cbit))
		            | (|(next_st.req_sat & next_st.mask_sat));
	end

	// state register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st.req_cbit  <= `CBI_REQ_RST;
			st.req_sat   <= `CBI_REQ_RST;
			st.mask_cbit <= `CBI_MASK_RST;
			st.mask_sat  <= `CBI_MASK_RST;
			st.rise      <= `CBI_RISE_RST;
			st.fall      <= `CBI_FALL_RST;
			st.ack       <= 1'b0;
			st.rdat      <= `CBI_RDAT_RST;
			st.irq       <= 1'b0;
		end
		else
			st <= next_st;
	end

	// outputs straight from flip-flops, upper data bits read as zero
	assign wb_o.ack = st.ack;
	assign wb_o.dat = {24'h000000, st.rdat};
	assign irq_o    = st.irq;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	irq_cbit_a: assert property (|(st.req_cbit & st.mask_cbit) |-> irq_o)
		else $error("unmasked c-bit request without interrupt");

	irq_sat_a: assert property (|(st.req_sat & st.mask_sat) |-> irq_o)
		else $error("unmasked saturation request without interrupt");

	irq_release_a: assert property (irq_o == ((|(st.req_cbit & st.mask_cbit))
		|| (|(st.req_sat & st.mask_sat))))
		else $error("interrupt level does not match unmasked requests");

	cbit_clear_a: assert property ((rd_commit && idx_hit(wb_i.adr, `CBI_IDX_REQ_CBIT))
		|=> ((st.req_cbit & $past(st.rdat) & ~$past(hit_cbit)) == 8'h00))
		else $error("c-bit request not cleared by read");

	sat_clear_a: assert property ((rd_commit && idx_hit(wb_i.adr, `CBI_IDX_REQ_SAT))
		|=> ((st.req_sat & $past(st.rdat) & ~$past(hit_sat)) == 8'h00))
		else $error("saturation request not cleared by read");

	sat_hold_a: assert property ((st.req_sat != 8'h00 && !rd_commit)
		|=> ((st.req_sat & $past(st.req_sat)) == $past(st.req_sat)))
		else $error("saturation request dropped without a read");

	cbit_entry_a: assert property ((st.rise && |(cbit_status_i & ~$past(cbit_status_i)))
		|=> ((st.req_cbit & $past(cbit_status_i & ~$past(cbit_status_i))) != 8'h00))
		else $error("c-bit entry not latched");

	sat_exit_a: assert property ((st.fall && |(~sat_i & $past(sat_i)))
		|=> ((st.req_sat & $past(~sat_i & $past(sat_i))) != 8'h00))
		else $error("saturation exit not latched");

	no_edge_a: assert property ((!st.rise && !st.fall)
		|=> ((st.req_cbit & ~$past(st.req_cbit)) == 8'h00))
		else $error("c-bit request set with both edges off");

	fcs_set_a: assert property ((st.rise && $rose(sat_i.fcs_count_full_req))
		|=> st.req_sat[`CBI_FCS_BIT])
		else $error("fcs saturation not latched");

	abort_set_a: assert property ((st.rise && $rose(sat_i.abort_count_full_req))
		|=> st.req_sat[`CBI_ABORT_BIT])
		else $error("abort saturation not latched");

	febe_set_a: assert property ((st.rise && $rose(sat_i.farend_block_err_count_full_req))
		|=> st.req_sat[`CBI_FEBE_BIT])
		else $error("far-end block error saturation not latched");

	cpar_set_a: assert property ((st.rise && $rose(sat_i.cparity_count_full_req))
		|=> st.req_sat[`CBI_CPAR_BIT])
		else $error("c-bit parity saturation not latched");

	ppar_set_a: assert property ((st.rise && $rose(sat_i.pparity_count_full_req))
		|=> st.req_sat[`CBI_PPAR_BIT])
		else $error("p-bit parity saturation not latched");

	fmerr_set_a: assert property ((st.rise && $rose(sat_i.frame_multiframe_err_count_full_req))
		|=> st.req_sat[`CBI_FMERR_BIT])
		else $error("f and m bit error saturation not latched");

	c1z_set_a: assert property ((st.rise && $rose(sat_i.c1_zero_count_full_req))
		|=> st.req_sat[`CBI_C1Z_BIT])
		else $error("c1 zero saturation not latched");

	merr_set_a: assert property ((st.rise && $rose(sat_i.multiframe_err_count_full_req))
		|=> st.req_sat[`CBI_MERR_BIT])
		else $error("m bit error saturation not latched");

	bus_ack_a: assert property (start |=> wb_o.ack ##1 !wb_o.ack)
		else $error("ack not one cycle after strobe");

	// ----------------------------------------------------------------
	// bus and register assertions
	// ----------------------------------------------------------------
	// ack is a single pulse answering a strobe
	ack_drop_a: assert property (wb_o.ack |=> !wb_o.ack)
		else $error("ack high for more than one cycle");

	ack_source_a: assert property ($rose(wb_o.ack) |-> $past(wb_i.cyc && wb_i.stb))
		else $error("ack without a request");

	// read data shape
	dat_upper_a: assert property (wb_o.dat[31:8] == 24'h000000)
		else $error("upper read data bits not zero");

	write_dat_a: assert property ((start && wb_i.we) |=> (wb_o.dat[7:0] == 8'h00))
		else $error("write cycle returned nonzero data");

	rdat_keep_a: assert property (!start |=> $stable(st.rdat))
		else $error("read data changed without a request");

	// read data taken at the take edge
	rd_req_cbit_a: assert property ((start && !wb_i.we && idx_hit(wb_i.adr, `CBI_IDX_REQ_CBIT))
		|=> (wb_o.dat[7:0] == $past(st.req_cbit)))
		else $error("c-bit request read data wrong");

	rd_req_sat_a: assert property ((start && !wb_i.we && idx_hit(wb_i.adr, `CBI_IDX_REQ_SAT))
		|=> (wb_o.dat[7:0] == $past(st.req_sat)))
		else $error("saturation request read data wrong");

	rd_status_a: assert property ((start && !wb_i.we && idx_hit(wb_i.adr, `CBI_IDX_STATUS))
		|=> (wb_o.dat[7:0] == $past(cbit_status_i)))
		else $error("status read data wrong");

	// mask and edge control writes land, and nothing else moves them
	mask_cbit_wr_a: assert property ((wr_lo && idx_hit(wb_i.adr, `CBI_IDX_MASK_CBIT))
		|=> (st.mask_cbit == $past(wb_i.dat[7:0])))
		else $error("c-bit mask write lost");

	mask_sat_wr_a: assert property ((wr_lo && idx_hit(wb_i.adr, `CBI_IDX_MASK_SAT))
		|=> (st.mask_sat == $past(wb_i.dat[7:0])))
		else $error("saturation mask write lost");

	mask_cbit_keep_a: assert property (!(wr_lo && idx_hit(wb_i.adr, `CBI_IDX_MASK_CBIT))
		|=> $stable(st.mask_cbit))
		else $error("c-bit mask changed without a write");

	mask_sat_keep_a: assert property (!(wr_lo && idx_hit(wb_i.adr, `CBI_IDX_MASK_SAT))
		|=> $stable(st.mask_sat))
		else $error("saturation mask changed without a write");

	edge_wr_a: assert property ((wr_lo && idx_hit(wb_i.adr, `CBI_IDX_EDGE_CTRL))
		|=> ((st.rise == $past(wb_i.dat[`CBI_EDGE_RISE_BIT]))
		&& (st.fall == $past(wb_i.dat[`CBI_EDGE_FALL_BIT]))))
		else $error("edge control write lost");

	edge_keep_a: assert property (!(wr_lo && idx_hit(wb_i.adr, `CBI_IDX_EDGE_CTRL))
		|=> ($stable(st.rise) && $stable(st.fall)))
		else $error("edge control changed without a write");

	// ----------------------------------------------------------------
	// request assertions
	// ----------------------------------------------------------------
	// c-bit requests stay until their register is read
	cbit_hold_a: assert property ((st.req_cbit != 8'h00 && !rd_commit)
		|=> ((st.req_cbit & $past(st.req_cbit)) == $past(st.req_cbit)))
		else $error("c-bit request dropped without a read");

	// a mask write gates only the interrupt
	mask_keeps_req_a: assert property ((wr_lo && idx_hit(wb_i.adr, `CBI_IDX_MASK_SAT))
		|=> ((st.req_sat & $past(st.req_sat)) == $past(st.req_sat)))
		else $error("mask write cleared a saturation request");

	// edge selection on the other directions
	cbit_exit_a: assert property ((st.fall && |(~cbit_status_i & $past(cbit_status_i)))
		|=> ((st.req_cbit & $past(~cbit_status_i & $past(cbit_status_i))) != 8'h00))
		else $error("c-bit exit not latched");

	sat_entry_a: assert property ((st.rise && |(sat_i & ~$past(sat_i)))
		|=> ((st.req_sat & $past(sat_i & ~$past(sat_i))) != 8'h00))
		else $error("saturation entry not latched");

	sat_no_edge_a: assert property ((!st.rise && !st.fall)
		|=> ((st.req_sat & ~$past(st.req_sat)) == 8'h00))
		else $error("saturation request set with both edges off");

	// a new c-bit request only comes from a detected edge
	cbit_set_src_a: assert property (1'b1
		|=> ((st.req_cbit & ~$past(st.req_cbit) & ~$past(hit_cbit)) == 8'h00))
		else $error("c-bit request set without an edge");

	// interrupt released when nothing unmasked is pending
	irq_idle_a: assert property ((!(|(st.req_cbit & st.mask_cbit))
		&& !(|(st.req_sat & st.mask_sat))) |-> !irq_o)
		else $error("interrupt active with no unmasked request");

	// ----------------------------------------------------------------
	// covers
	// ----------------------------------------------------------------
	cbit_read_c: cover property (rd_commit && idx_hit(wb_i.adr, `CBI_IDX_REQ_CBIT)
		&& st.req_cbit != 8'h00);

	irq_rise_c: cover property ($rose(irq_o));

	irq_fall_c: cover property ($fell(irq_o));

	both_edges_c: cover property (st.rise && st.fall && hit_sat != 8'h00);

	edge_off_c: cover property (!st.rise && !st.fall && start);

endmodule

/* cbi_params.svh */
/*
 constants of the c-bit status and counter saturation interrupt latch:
 register indices, field positions and reset values.
 assumes it is included by cbi_irq_latch.sv by bare name; cbi_pkg.sv does not include it.
*/
// Operation
// - one latched request bit per bit of the c-bit status register
// - interrupt active while a c-bit request and its mask bit are both 1
// - reading the c-bit request register clears its set bits
// - rise and fall bits pick entry, exit or both edges for setting requests
// - bit 7 sets when the receive fcs error counter saturates
// - bit 6 sets when the receive abort counter saturates
// - bit 5 sets when the far-end block / f-and-m error counter saturates
// - bit 4 sets when the c-bit parity / frames counter saturates
// - bit 3 sets when the p-bit parity counter saturates
// - bit 2 sets when the f-bits and m-bits in error counter saturates
// - bit 1 sets when the c1-equal-zero counter saturates
// - bit 0 sets when the m-bits in error counter saturates
// - saturation requests stay latched until read; the read clears only the bits it reported
// - interrupt active while a saturation request and its mask bit are 1
`ifndef CBI_PARAMS_SVH
`define CBI_PARAMS_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define CBI_IDX_STATUS     6'h03
`define CBI_IDX_REQ_CBIT   6'h2a
`define CBI_IDX_REQ_SAT    6'h2b
`define CBI_IDX_MASK_CBIT  6'h33
`define CBI_IDX_MASK_SAT   6'h34
`define CBI_IDX_EDGE_CTRL  6'h3f

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CBI_EDGE_RISE_BIT  1
`define CBI_EDGE_FALL_BIT  0
`define CBI_FCS_BIT        7
`define CBI_ABORT_BIT      6
`define CBI_FEBE_BIT       5
`define CBI_CPAR_BIT       4
`define CBI_PPAR_BIT       3
`define CBI_FMERR_BIT      2
`define CBI_C1Z_BIT        1
`define CBI_MERR_BIT       0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CBI_REQ_RST        8'h00
`define CBI_MASK_RST       8'h00
`define CBI_RISE_RST       1'b1
`define CBI_FALL_RST       1'b0
`define CBI_RDAT_RST       8'h00

`endif

/* cbi_pkg.sv */
/*
 types of the interrupt latch: bus carriers, saturation flags, state.
 assumes cbi_params.svh sits in the same folder.
*/
package cbi_pkg;

	// ----------------------------------------------------------------
	// wishbone carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} cbi_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} cbi_wb_rsp_t;

	// saturation flags of the eight counters, msb first
	typedef struct packed {
		logic fcs_count_full_req;
		logic abort_count_full_req;
		logic farend_block_err_count_full_req;
		logic cparity_count_full_req;
		logic pparity_count_full_req;
		logic frame_multiframe_err_count_full_req;
		logic c1_zero_count_full_req;
		logic multiframe_err_count_full_req;
	} cbi_sat_t;

	// state of the edge detector
	typedef struct packed {
		logic [7:0] prev;
	} cbi_edge_state_t;

	// state of the top module
	typedef struct packed {
		logic [7:0] req_cbit;
		logic [7:0] req_sat;
		logic [7:0] mask_cbit;
		logic [7:0] mask_sat;
		logic       rise;
		logic       fall;
		logic       ack;
		logic [7:0] rdat;
		logic       irq;
	} cbi_state_t;

endpackage

/* cbi_edge8.sv */
/*
 eight-bit edge detector with entry and exit select.
 assumes conditions come from logic on the same clock.
*/
module cbi_edge8
(
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] cond_i,
	input  wire logic       rise_i,
	input  wire logic       fall_i,
	output logic      [7:0] hit_o
);
	import cbi_pkg::*;

	cbi_edge_state_t st;
	cbi_edge_state_t next_st;

	// ----------------------------------------------------------------
	// edge select
	// ----------------------------------------------------------------
	// entry, exit or both edges flag a hit
	always_comb
	begin
		next_st.prev = cond_i;
		hit_o = (cond_i & ~st.prev & {8{rise_i}})
		      | (~cond_i & st.prev & {8{fall_i}});
	end

	// previous condition register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st.prev <= 8'h00;
		else
			st <= next_st;
	end

endmodule

/* cbi_host.sv */
/*
 host model: a classic wishbone master making single read and write cycles.
 assumes the bench watchdog ends any wait for ack that never comes.
*/
module cbi_host
(
	input  wire logic                 clk_i,
	input  wire cbi_pkg::cbi_wb_rsp_t wb_i,
	output cbi_pkg::cbi_wb_req_t      wb_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import cbi_pkg::*;

	// ----------------------------------------------------------------
	// bus cycle
	// ----------------------------------------------------------------
	initial wb_o = '0;

	// hold the request until ack is sampled, take data there, then release
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
		output logic [31:0] rd);
		@(posedge clk_i);
		wb_o <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: adr, dat: {24'h000000, wd}};
		do
			@(posedge clk_i);
		while (wb_i.ack !== 1'b1);
		rd = wb_i.dat;
		wb_o <= '0;
	endtask
endmodule

/* cbi_irq_latch_tb_top.sv */
/*
 self-checking bench of the interrupt request latch.
 assumes cbi_host drives the bus and the bench drives the condition levels.
*/
module cbi_irq_latch_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cbi_pkg::*;

	localparam logic [7:0] A_ST  = 8'h0c;
	localparam logic [7:0] A_RQC = 8'ha8;
	localparam logic [7:0] A_RQS = 8'hac;
	localparam logic [7:0] A_MKC = 8'hcc;
	localparam logic [7:0] A_MKS = 8'hd0;
	localparam logic [7:0] A_EDG = 8'hfc;
	localparam logic [7:0] A_NON = 8'h40;

	logic        clk_i;
	logic        rst_i;
	cbi_wb_req_t wb_req;
	cbi_wb_rsp_t wb_rsp;
	logic [7:0]  cbit_status;
	cbi_sat_t    sat;
	logic        irq;
	logic [31:0] rd;
	int          error_cnt;
	int          samples_checked;

	// ----------------------------------------------------------------
	// design and host
	// ----------------------------------------------------------------
	cbi_irq_latch i_cbi_irq_latch (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_req), .wb_o(wb_rsp),
		.cbit_status_i(cbit_status), .sat_i(sat), .irq_o(irq));
	cbi_host i_cbi_host (.clk_i(clk_i), .wb_i(wb_rsp), .wb_o(wb_req));

	// 200 mhz clock
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		i_cbi_host.xfer(1'b0, a, 8'h00, rd);
		chk(rd, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_cbi_host.xfer(1'b1, a, d, rd);
	endtask

	// irq looked at mid-cycle, after the edge updates landed
	task automatic irq_chk(input logic exp);
		@(negedge clk_i);
		chk({31'h0, irq}, {31'h0, exp});
	endtask

	// new condition levels, then the note's latency to the request
	task automatic cond(input logic [7:0] c, input logic [7:0] s);
		@(posedge clk_i);
		cbit_status <= c;
		sat <= s;
		repeat (2) @(posedge clk_i);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		irq_chk(1'b0);
		rd_chk(A_RQC, 32'h0);
		rd_chk(A_RQS, 32'h0);
		rd_chk(A_MKC, 32'h0);
		rd_chk(A_MKS, 32'h0);
		rd_chk(A_EDG, 32'h2);
		wr(A_NON, 8'hff);
		rd_chk(A_NON, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_cbit;
		wr(A_MKC, 8'h81);
		cond(8'h83, 8'h00);
		irq_chk(1'b1);
		rd_chk(A_ST, 32'h83);
		rd_chk(A_RQC, 32'h83);
		irq_chk(1'b0);
		rd_chk(A_RQC, 32'h0);
		cond(8'h06, 8'h00);
		irq_chk(1'b0);
		rd_chk(A_RQC, 32'h04);
		cond(8'h00, 8'h00);
		rd_chk(A_RQC, 32'h0);
		$display("test cbit done");
	endtask

	task automatic t_sat;
		wr(A_MKS, 8'hff);
		for (int k = 0; k < 8; k++)
		begin
			cond(8'h00, 8'h01 << k);
			irq_chk(1'b1);
			rd_chk(A_RQS, 32'h1 << k);
			irq_chk(1'b0);
			cond(8'h00, 8'h00);
		end
		$display("test saturation done");
	endtask

	task automatic t_latch;
		wr(A_MKS, 8'h80);
		cond(8'h00, 8'h80);
		repeat (8) @(posedge clk_i);
		irq_chk(1'b1);
		wr(A_MKS, 8'h00);
		irq_chk(1'b0);
		wr(A_MKS, 8'h80);
		irq_chk(1'b1);
		cond(8'h00, 8'h81);
		rd_chk(A_RQS, 32'h81);
		irq_chk(1'b0);
		cond(8'h00, 8'h00);
		$display("test latch done");
	endtask

	// each edge mode: entry then exit on both request registers
	task automatic t_edge;
		for (int m = 0; m < 4; m++)
		begin
			wr(A_EDG, m[7:0]);
			rd_chk(A_EDG, m);
			cond(8'h01, 8'h01);
			rd_chk(A_RQC, {31'h0, m[1]});
			rd_chk(A_RQS, {31'h0, m[1]});
			cond(8'h00, 8'h00);
			rd_chk(A_RQC, {31'h0, m[0]});
			rd_chk(A_RQS, {31'h0, m[0]});
		end
		$display("test edge done");
	endtask

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task automatic summarize;
		$display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// main sequence
	initial
	begin
		rst_i = 1'b1;
		cbit_status = 8'h00;
		sat = '0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		t_reset();
		t_cbit();
		t_sat();
		t_latch();
		t_edge();
		summarize();
	end

	// watchdog, far beyond the roughly 300 cycles the tests need
	initial
	begin
		#50000;
		error_cnt++;
		$display("watchdog expired");
		summarize();
	end
endmodule
